// ===== hw/eio_defines.vh
// eio_defines.vh: offsets, field positions and reset values of the port block
// assumes an APB slave with 32-bit data, one register per aligned word
`ifndef EIO_DEFINES_VH
`define EIO_DEFINES_VH
`define EIO_OFS_WPIN      12'h000
`define EIO_OFS_WLAT      12'h004
`define EIO_OFS_WDIR      12'h008
`define EIO_OFS_SDIR      12'h00C
`define EIO_OFS_SPIN      12'h010
`define EIO_OFS_SLAT      12'h014
`define EIO_OFS_ANSEL     12'h018
`define EIO_OFS_SPDATA    12'h01C
`define EIO_OFS_IRQ_STAT  12'h020
`define EIO_OFS_IRQ_MASK  12'h024
`define EIO_BIT_IBF       7
`define EIO_BIT_OBF       6
`define EIO_BIT_OVF       5
`define EIO_BIT_PSP       4
`define EIO_RST_WDIR      8'hFF
`define EIO_RST_SDIR_LO   3'h7
`define EIO_RST_ANSEL     3'h7
`define EIO_IRQ_IN        0
`define EIO_IRQ_OUT       1
`define EIO_IRQ_OVF       2
`endif

// ===== hw/eio_ports.v
// eio_ports.v: 8-bit port with slave-port data, 3-bit port with analog select
// assumes a single clock; pins and slave strobes are synchronous to clk
`timescale 1ns/100ps
`default_nettype none
`include "eio_defines.vh"

// Contract
// - small-port direction 1 floats pin driver, 0 drives latch value
// - small-port latch register reads back latched values, not pins
// - small-port pins selected analog read as zero
// - small-port direction bits still control drivers while analog
// - power-on reset selects all three small-port pins as analog
// - input-full flag bit 7 is 1 while received word unread
// - output-full flag bit 6 is 1 until written word is read
// - bit 4 selects slave-port mode for the 8-bit port
// - each 8-bit pin is plain I/O or matching slave data bit
// - direction/status layout ibf,obf,ovf,psp,-,dir2..0, reset 0000-111
// - unimplemented bits read zero and ignore writes
// - 8-bit latch unknown at power-on, unchanged by other resets
// - 8-bit direction resets to all ones on rst; por leaves it unchanged
// - 8-bit port write updates latch, read returns pin levels
module eio_ports (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  input  wire        por,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // 8-bit port pins
  input  wire [7:0]  wide_pin_in,
  output reg  [7:0]  wide_pin_out,
  output reg  [7:0]  wide_pin_oe_n,
  // 3-bit port pins
  input  wire [2:0]  small_pin_in,
  output reg  [2:0]  small_pin_out,
  output reg  [2:0]  small_pin_oe_n,
  // external slave-port strobes, one-cycle pulses
  input  wire        ext_write_stb,
  input  wire        ext_read_stb,
  // interrupt
  output reg         irq
);

  reg [7:0] wlat_r;
  reg [7:0] wdir_r;
  reg [2:0] sdir_r;
  reg [2:0] slat_r;
  reg [2:0] ansel_r;
  reg       ibf_r;
  reg       obf_r;
  reg       ovf_r;
  reg       psp_r;
  reg [7:0] in_word_r;
  reg [2:0] ist_r;
  reg [2:0] imsk_r;
  reg [31:0] rd_nxt;
  reg        hit_nxt;

  wire acc    = psel & penable & ~pready;
  wire wr_acc = acc & pwrite;
  wire rd_acc = acc & ~pwrite;

  function sel;
    input [11:0] a;
    input [11:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  wire wr_wpin   = wr_acc & sel(paddr, `EIO_OFS_WPIN);
  wire wr_wlat   = wr_acc & sel(paddr, `EIO_OFS_WLAT);
  wire wr_sdir   = wr_acc & sel(paddr, `EIO_OFS_SDIR);
  wire rd_spdata = rd_acc & sel(paddr, `EIO_OFS_SPDATA);
  wire ext_wr    = psp_r & ext_write_stb;
  wire ext_rd    = psp_r & ext_read_stb;

  // register read mux
  always @* begin
    rd_nxt  = 32'h0000_0000;
    hit_nxt = 1'b1;
    case (paddr)
      `EIO_OFS_WPIN:     rd_nxt[7:0] = wide_pin_in;
      `EIO_OFS_WLAT:     rd_nxt[7:0] = wlat_r;
      `EIO_OFS_WDIR:     rd_nxt[7:0] = wdir_r;
      `EIO_OFS_SDIR:     rd_nxt[7:0] = {ibf_r, obf_r, ovf_r, psp_r, 1'b0, sdir_r};
      `EIO_OFS_SPIN:     rd_nxt[2:0] = small_pin_in & ~ansel_r;
      `EIO_OFS_SLAT:     rd_nxt[2:0] = slat_r;
      `EIO_OFS_ANSEL:    rd_nxt[2:0] = ansel_r;
      `EIO_OFS_SPDATA:   rd_nxt[7:0] = in_word_r;
      `EIO_OFS_IRQ_STAT: rd_nxt[2:0] = ist_r;
      `EIO_OFS_IRQ_MASK: rd_nxt[2:0] = imsk_r;
      default:           hit_nxt     = 1'b0;
    endcase
  end

  // apb answer, one wait state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~hit_nxt;
      prdata  <= rd_acc ? rd_nxt : 32'h0000_0000;
    end
  end

  always @(posedge clk) begin
    if (wr_wpin | wr_wlat) begin
      wlat_r <= pwdata[7:0];
    end
  end

  // control registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wdir_r  <= `EIO_RST_WDIR;
      sdir_r  <= `EIO_RST_SDIR_LO;
      psp_r   <= 1'b0;
      slat_r  <= 3'h0;
      imsk_r  <= 3'h0;
    end else if (wr_acc) begin
      if (sel(paddr, `EIO_OFS_WDIR)) begin
        wdir_r <= pwdata[7:0];
      end
      if (wr_sdir) begin
        psp_r  <= pwdata[`EIO_BIT_PSP];
        sdir_r <= pwdata[2:0];
      end
      if (sel(paddr, `EIO_OFS_SLAT) | sel(paddr, `EIO_OFS_SPIN)) begin
        slat_r <= pwdata[2:0];
      end
      if (sel(paddr, `EIO_OFS_IRQ_MASK)) begin
        imsk_r <= pwdata[2:0];
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ansel_r <= `EIO_RST_ANSEL;
    end else if (por) begin
      ansel_r <= `EIO_RST_ANSEL;
    end else if (wr_acc & sel(paddr, `EIO_OFS_ANSEL)) begin
      ansel_r <= pwdata[2:0];
    end
  end

  // slave-port buffer flags
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ibf_r     <= 1'b0;
      obf_r     <= 1'b0;
      ovf_r     <= 1'b0;
      in_word_r <= 8'h00;
    end else begin
      // set on external write, clear on cpu read
      if (ext_wr) begin
        ibf_r     <= 1'b1;
        in_word_r <= wide_pin_in;
      end else if (rd_spdata) begin
        ibf_r <= 1'b0;
      end
      // set on cpu write, clear on external read
      if (wr_wpin | wr_wlat) begin
        obf_r <= 1'b1;
      end else if (ext_rd) begin
        obf_r <= 1'b0;
      end
      if (ext_wr & ibf_r & ~rd_spdata) begin
        ovf_r <= 1'b1;
      end else if (wr_sdir & ~pwdata[`EIO_BIT_OVF]) begin
        ovf_r <= 1'b0;
      end
    end
  end

  // interrupt status, write one to clear, set wins
  wire [2:0] ev = {ext_wr & ibf_r & ~rd_spdata, ext_rd, ext_wr};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ist_r <= 3'h0;
      irq   <= 1'b0;
    end else begin
      if (wr_acc & sel(paddr, `EIO_OFS_IRQ_STAT)) begin
        ist_r <= (ist_r & ~pwdata[2:0]) | ev;
      end else begin
        ist_r <= ist_r | ev;
      end
      irq <= |(ist_r & imsk_r);
    end
  end

  // pin drivers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wide_pin_out   <= 8'h00;
      wide_pin_oe_n  <= 8'hFF;
      small_pin_out  <= 3'h0;
      small_pin_oe_n <= 3'h7;
    end else begin
      wide_pin_out  <= wlat_r;
      wide_pin_oe_n <= psp_r ? {8{~ext_read_stb}} : wdir_r;
      small_pin_out  <= slat_r;
      small_pin_oe_n <= sdir_r;
    end
  end

endmodule
`default_nettype wire

// ===== tb/eio_chk.sv
// eio_chk.sv: assertions on apb answers and pin enables of eio_ports
// assumes one clock, async active-high reset
`timescale 1ns/100ps
`default_nettype none
module eio_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  wide_pin_oe_n,
  input wire logic [2:0]  small_pin_oe_n
);
  logic [2:0] dir_q;
  always_ff @(posedge clk) dir_q <= pwdata[2:0];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence taken_s; psel && penable && !pready; endsequence
  sequence sdir_rd_s; pready && paddr == 12'h00C && !pwrite; endsequence
  sequence sdir_wr_s; pready && paddr == 12'h00C && pwrite; endsequence
  ready_follows_a: assert property (taken_s |=> pready) else $error("no answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
  err_pulse_a: assert property (pslverr |-> pready) else $error("stray error");
  err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0) else $error("error data");
  sdir_bits_a:
    assert property (sdir_rd_s |-> prdata[31:8] == 24'h0 && !prdata[3]) else $error("bit3");
  small_dir_a:
    assert property (sdir_wr_s |=> small_pin_oe_n == dir_q) else $error("small dir");
  reset_dir_a:
    assert property ($fell(rst) |-> wide_pin_oe_n == 8'hFF && small_pin_oe_n == 3'h7)
      else $error("reset dir");
endmodule
bind eio_ports eio_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .wide_pin_oe_n(wide_pin_oe_n), .small_pin_oe_n(small_pin_oe_n));
`default_nettype wire

// ===== tb/testbench.sv
// testbench.sv: self-checking bench for eio_ports
// assumes the design and its checker bind are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 0, rst = 1, por = 1, psel = 0, penable = 0, pwrite = 0;
  logic ext_write_stb = 0, ext_read_stb = 0, pready, pslverr, irq;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [7:0] wide_pin_in = 8'h00, wide_pin_out, wide_pin_oe_n;
  logic [2:0] small_pin_in = 3'h7, small_pin_out, small_pin_oe_n;
  int n_fail = 0, cmp_count = 0;
  always #4 clk = ~clk;
  eio_ports dut (.clk, .rst, .por, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .wide_pin_in, .wide_pin_out, .wide_pin_oe_n, .small_pin_in,
    .small_pin_out, .small_pin_oe_n, .ext_write_stb, .ext_read_stb, .irq);
  task automatic chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic wstb(input logic [7:0] v);
    wide_pin_in <= v;
    ext_write_stb <= 1;
    @(posedge clk);
    ext_write_stb <= 0;
    @(posedge clk);
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    por <= 0;
    @(posedge clk);
    rd(12'h008, 32'hFF);
    rd(12'h00C, 32'h07);
    rd(12'h018, 32'h07);
    rd(12'h010, 32'h00);
    rd(12'h0FC, 32'h00);
    $display("reset test done");
    small_pin_in <= 3'h2;
    apb(1, 12'h018, 32'h0);
    apb(1, 12'h014, 32'h5);
    apb(1, 12'h00C, 32'hCA);
    chk(small_pin_out, 32'h5);
    rd(12'h014, 32'h05);
    rd(12'h010, 32'h02);
    rd(12'h00C, 32'h02);
    $display("small port test done");
    wide_pin_in <= 8'h3C;
    apb(1, 12'h008, 32'h0);
    apb(1, 12'h000, 32'hA5);
    chk(wide_pin_out, 32'hA5);
    chk(wide_pin_oe_n, 32'h00);
    rd(12'h000, 32'h3C);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(12'h004, 32'hA5);
    rd(12'h008, 32'hFF);
    $display("wide port test done");
    apb(1, 12'h018, 32'h0);
    apb(1, 12'h00C, 32'h17);
    apb(1, 12'h000, 32'h11);
    rd(12'h00C, 32'h57);
    ext_read_stb <= 1;
    @(posedge clk);
    ext_read_stb <= 0;
    @(posedge clk);
    rd(12'h00C, 32'h17);
    wstb(8'h5A);
    rd(12'h00C, 32'h97);
    rd(12'h01C, 32'h5A);
    rd(12'h00C, 32'h17);
    wstb(8'h66);
    wstb(8'h66);
    rd(12'h00C, 32'hB7);
    chk(irq, 32'h0);
    apb(1, 12'h024, 32'h4);
    chk(irq, 32'h1);
    apb(1, 12'h020, 32'h7);
    chk(irq, 32'h0);
    apb(1, 12'h00C, 32'h17);
    rd(12'h00C, 32'h97);
    $display("slave port test done");
    conclude;
  end
  initial begin
    #100000;
    n_fail++;
    conclude;
  end
endmodule
`default_nettype wire
